/* amc_pkg.sv */
package amc_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [5:0] IDX_STATUS   = 6'h01;
  localparam logic [5:0] IDX_MODE     = 6'h02;
  localparam logic [5:0] IDX_CLOCK    = 6'h03;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h11;

  // ****************************************************************
  // Reset values and field positions.
  // ****************************************************************
  localparam logic [15:0] MODE_RST     = 16'h0510;
  localparam logic [15:0] CLOCK_RST    = 16'h0F0E;
  localparam logic [15:0] CLOCK_WMASK  = 16'h0FFF;
  localparam int          POS_REGCRC   = 13;
  localparam int          POS_RXCRC    = 12;
  localparam int          POS_CRCTYPE  = 11;
  localparam int          POS_RSTFLAG  = 10;
  localparam int          POS_TIMEOUT  = 4;
  localparam int          POS_TURBO    = 5;
  localparam logic [14:0] OSR_TURBO    = 15'h0040;
  localparam logic [14:0] OSR_BASE     = 15'h0080;
  localparam int          IRQ_W        = 6;

  // ****************************************************************
  // Timing of the data-ready low pulse.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_NS      = 160;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    AMC_SRC_LAGGING,
    AMC_SRC_OR,
    AMC_SRC_LEADING,
    AMC_SRC_LEADING2
  } amc_src_e;

  typedef struct packed {
    logic     [1:0] reserved_hi;
    logic           regmap_crc_enable;
    logic           rx_crc_enable;
    logic           crc_type_ansi;
    logic           reset_occurred;
    logic     [1:0] word_size_select;
    logic     [2:0] reserved_lo;
    logic           timeout_enable;
    amc_src_e       ready_source_select;
    logic           ready_idle_tristate;
    logic           ready_pulse_format;
  } amc_mode_s;

  typedef struct packed {
    logic [3:0] reserved_hi;
    logic       chan3_enable;
    logic       chan2_enable;
    logic       chan1_enable;
    logic       chan0_enable;
    logic [1:0] reserved_lo;
    logic       turbo_ratio_override;
    logic [2:0] oversample_ratio_select;
    logic [1:0] power_mode_select;
  } amc_clock_s;

endpackage

/* amc_regs.sv */
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module amc_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [3:0]           conv_done,
  input  wire logic [3:0]           data_taken,
  input  wire logic                 rx_crc_fail,
  input  wire logic [15:0]          regmap_crc,
  output amc_pkg::amc_mode_s        mode_cfg,
  output amc_pkg::amc_clock_s       clock_cfg,
  output logic      [14:0]          osr_ratio,
  output logic                      conversion_ready_pin,
  output logic                      conversion_ready_oe_n,
  output logic                      irq
);

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        access_w;
  logic        done_w;
  logic        mapped_w;
  logic [5:0]  idx_w;
  logic [15:0] rd_w;

  logic [15:0] mode_q;
  logic [15:0] clock_q;
  logic [3:0]  new_data_q;
  logic        crc_err_q;
  logic        map_fault_q;
  logic [15:0] crc_prev_q;
  logic        crc_armed_q;

  localparam int IRQ_W_L = amc_pkg::IRQ_W;

  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_mask_q;
  logic        irq_q;
  logic [14:0] osr_q;
  logic [15:0] status_w;
  logic        wr_mode_w;
  logic        wr_clock_w;
  logic        rd_status_w;
  logic [3:0]  en_w;

  assign access_w = psel & penable;
  assign done_w   = access_w & pready_q;
  assign idx_w    = paddr[7:2];
  assign en_w     = clock_q[11:8];

  always_comb begin
    mapped_w = 1'b1;
    rd_w     = 16'h0000;
    case (idx_w)
      amc_pkg::IDX_STATUS:   rd_w = status_w;
      amc_pkg::IDX_MODE:     rd_w = mode_q;
      amc_pkg::IDX_CLOCK:    rd_w = clock_q;
      amc_pkg::IDX_IRQ_STAT: rd_w = {{(16 - IRQ_W_L){1'b0}}, irq_stat_q};
      amc_pkg::IDX_IRQ_MASK: rd_w = {{(16 - IRQ_W_L){1'b0}}, irq_mask_q};
      default:               mapped_w = 1'b0;
    endcase
  end

  // One wait state: the answer is computed in the first access cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access_w & ~pready_q;
      pslverr_q <= access_w & ~pready_q & ~mapped_w;
      if (access_w & ~pready_q & ~pwrite) begin
        prdata_q <= {16'h0000, rd_w};
      end
    end
  end

  assign wr_mode_w   = done_w & pwrite & (idx_w == amc_pkg::IDX_MODE);
  assign wr_clock_w  = done_w & pwrite & (idx_w == amc_pkg::IDX_CLOCK);
  assign rd_status_w = done_w & ~pwrite & (idx_w == amc_pkg::IDX_STATUS);

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  // mode reset value
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q <= amc_pkg::MODE_RST;
    end else if (wr_mode_w) begin
      mode_q <= pwdata[15:0] & ~(16'h0001 << amc_pkg::POS_RSTFLAG)
              | ({15'h0000, mode_q[amc_pkg::POS_RSTFLAG] & pwdata[amc_pkg::POS_RSTFLAG]}
                 << amc_pkg::POS_RSTFLAG);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clock_q <= amc_pkg::CLOCK_RST;
    end else if (wr_clock_w) begin
      clock_q <= pwdata[15:0] & amc_pkg::CLOCK_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      osr_q <= amc_pkg::OSR_BASE;
    end else if (clock_q[amc_pkg::POS_TURBO]) begin
      osr_q <= amc_pkg::OSR_TURBO;
    end else begin
      osr_q <= amc_pkg::OSR_BASE << clock_q[4:2];
    end
  end

  // ****************************************************************
  // Status flags.
  // ****************************************************************
  // per-channel new data, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      new_data_q <= 4'h0;
    end else begin
      new_data_q <= ((new_data_q & ~data_taken) | conv_done) & en_w;
    end
  end

  // Sticky faults clear on a status read; a new event in that cycle wins.
  // input CRC failure flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      crc_err_q <= 1'b0;
    end else begin
      crc_err_q <= (crc_err_q & ~rd_status_w) | (rx_crc_fail & mode_q[amc_pkg::POS_RXCRC]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      crc_prev_q  <= 16'h0000;
      crc_armed_q <= 1'b0;
      map_fault_q <= 1'b0;
    end else begin
      crc_prev_q  <= regmap_crc;
      crc_armed_q <= mode_q[amc_pkg::POS_REGCRC];
      map_fault_q <= (map_fault_q & ~rd_status_w)
                   | (crc_armed_q & mode_q[amc_pkg::POS_REGCRC] & (regmap_crc != crc_prev_q));
    end
  end

  assign status_w = {2'b00, map_fault_q, crc_err_q, mode_q[amc_pkg::POS_CRCTYPE],
                     mode_q[amc_pkg::POS_RSTFLAG], mode_q[9:8], 4'h0, new_data_q};

  // ****************************************************************
  // Interrupts.
  // ****************************************************************
  logic [IRQ_W_L-1:0] irq_ev_w;
  logic               rd_irq_w;
  logic               wr_mask_w;

  assign irq_ev_w  = {(regmap_crc != crc_prev_q) & crc_armed_q & mode_q[amc_pkg::POS_REGCRC],
                      rx_crc_fail & mode_q[amc_pkg::POS_RXCRC],
                      conv_done & en_w};
  assign rd_irq_w  = done_w & ~pwrite & (idx_w == amc_pkg::IDX_IRQ_STAT);
  assign wr_mask_w = done_w & pwrite & (idx_w == amc_pkg::IDX_IRQ_MASK);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & {IRQ_W_L{~rd_irq_w}}) | irq_ev_w;
      if (wr_mask_w) begin
        irq_mask_q <= pwdata[IRQ_W_L-1:0];
      end
      irq_q <= |(((irq_stat_q & {IRQ_W_L{~rd_irq_w}}) | irq_ev_w) & irq_mask_q);
    end
  end

  // ****************************************************************
  // Data-ready pin.
  // ****************************************************************
  logic       lead_q;
  logic       cond_w;
  logic       cond_q;
  logic [2:0] pulse_cnt_q;
  logic       pin_q;
  logic       oe_n_q;
  logic       low_w;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lead_q <= 1'b0;
    end else begin
      lead_q <= (lead_q & ~|(data_taken & en_w)) | |(conv_done & en_w);
    end
  end

  always_comb begin
    case (mode_q[3:2])
      amc_pkg::AMC_SRC_LAGGING: cond_w = (en_w != 4'h0) & ((new_data_q & en_w) == en_w);
      amc_pkg::AMC_SRC_OR:      cond_w = |(new_data_q & en_w);
      default:                  cond_w = lead_q;
    endcase
  end

  // fixed-width low pulse on each new assertion
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cond_q      <= 1'b0;
      pulse_cnt_q <= 3'h0;
    end else begin
      cond_q <= cond_w;
      if (cond_w & ~cond_q) begin
        pulse_cnt_q <= 3'(amc_pkg::PULSE_CYC);
      end else if (pulse_cnt_q != 3'h0) begin
        pulse_cnt_q <= pulse_cnt_q - 3'h1;
      end
    end
  end

  assign low_w = mode_q[0] ? ((cond_w & ~cond_q) | (pulse_cnt_q > 3'h1)) : cond_w;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_q  <= 1'b1;
      oe_n_q <= 1'b0;
    end else begin
      pin_q  <= ~low_w;
      oe_n_q <= ~low_w & mode_q[1];
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // timeout enable exported
  assign mode_cfg              = mode_q;
  assign clock_cfg             = clock_q;
  assign osr_ratio             = osr_q;
  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign irq                   = irq_q;
  assign conversion_ready_pin  = pin_q;
  assign conversion_ready_oe_n = oe_n_q;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_mode_reset_val: assert property ($fell(srst) |-> $past(mode_q) == 16'h0510)
    else $error("mode register not at reset value");
  a_clock_reset_val: assert property ($fell(srst) |-> $past(clock_q) == 16'h0F0E)
    else $error("clock register not at reset value");
  a_clock_rsvd_zero: assert property (clock_q[15:12] == 4'h0)
    else $error("clock reserved bits not zero");
  a_rst_flag_sticky: assert property (!mode_q[10] |=> !mode_q[10])
    else $error("reset flag set again");
  a_turbo_ratio: assert property (clock_q[5] |=> osr_ratio == 15'h0040)
    else $error("turbo ratio not 64");
  a_ratio_field: assert property (!clock_q[5] && clock_q[4:2] == 3'h7 |=> osr_ratio == 15'h4000)
    else $error("ratio field mapping wrong");
  a_crc_err_set: assert property (rx_crc_fail && mode_q[12] |=> status_w[12])
    else $error("input CRC failure not flagged");
  a_crc_err_gated: assert property (!crc_err_q && !mode_q[12] |=> !crc_err_q)
    else $error("CRC flag set while check disabled");
  a_map_fault_set: assert property (crc_armed_q && mode_q[13] && regmap_crc != crc_prev_q
                                    |=> status_w[13])
    else $error("map CRC change not flagged");
  a_new_data_set: assert property (conv_done[0] && en_w[0] |=> status_w[0])
    else $error("new data flag not set");
  a_disabled_clear: assert property (!en_w[2] |=> !new_data_q[2])
    else $error("disabled channel flag set");
  a_or_source_pin: assert property (mode_q[3:2] == 2'b01 && !mode_q[0] && |(new_data_q & en_w)
                                    |=> !conversion_ready_pin)
    else $error("pin not low with OR source");
  a_pulse_width: assert property (mode_q[0] && $rose(cond_w)
                                  ##1 ($stable(mode_q) && !$rose(cond_w)) [*4]
                                  |=> conversion_ready_pin
                                      && !$past(conversion_ready_pin, 1)
                                      && !$past(conversion_ready_pin, 2)
                                      && !$past(conversion_ready_pin, 3)
                                      && !$past(conversion_ready_pin, 4))
    else $error("ready pulse width wrong");
  a_idle_tristate: assert property (mode_q[1] && !low_w |=> conversion_ready_oe_n)
    else $error("idle pin not released");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("slave answer late");

  c_status_read: cover property (rd_status_w && crc_err_q);
  c_pulse_mode: cover property (mode_q[0] && $rose(cond_w));
  c_irq_raise: cover property ($rose(irq));

endmodule // amc_regs

`default_nettype wire

/* amc_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stands in for the conversion engine and serial front end beside the
// register block. Each request held for one cycle becomes a one-cycle pulse,
// so the block sees events exactly as the live datapath would issue them.
module amc_far_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [3:0]  req_done,
  input  wire logic [3:0]  req_take,
  input  wire logic        req_fail,
  input  wire logic [15:0] req_crc,
  output logic      [3:0]  conv_done,
  output logic      [3:0]  data_taken,
  output logic             rx_crc_fail,
  output logic      [15:0] regmap_crc
);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_done   <= 4'h0;
      data_taken  <= 4'h0;
      rx_crc_fail <= 1'b0;
      regmap_crc  <= 16'h0000;
    end else begin
      conv_done   <= req_done;
      data_taken  <= req_take;
      rx_crc_fail <= req_fail;
      regmap_crc  <= req_crc;
    end
  end
endmodule // amc_far_model
`default_nettype wire

/* adc_mode_clock_config_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_mode_clock_config_regs_tb;
  localparam logic [7:0] A_ST = {amc_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_MD = {amc_pkg::IDX_MODE, 2'b00};
  localparam logic [7:0] A_CK = {amc_pkg::IDX_CLOCK, 2'b00};
  localparam logic [7:0] A_IS = {amc_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_IM = {amc_pkg::IDX_IRQ_MASK, 2'b00};
  logic                clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic                pin, oe_n, irq, req_fail, rx_crc_fail, e1;
  logic [3:0]          req_done, req_take, conv_done, data_taken;
  logic [7:0]          paddr;
  logic [14:0]         osr_ratio;
  logic [15:0]         req_crc, regmap_crc, m, c;
  logic [31:0]         pwdata, prdata, d;
  amc_pkg::amc_mode_s  mode_cfg;
  amc_pkg::amc_clock_s clock_cfg;
  int                  errors, compares, n;
  int                  cyc = 0;

  amc_regs u_dut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .data_taken(data_taken), .rx_crc_fail(rx_crc_fail), .regmap_crc(regmap_crc),
    .mode_cfg(mode_cfg), .clock_cfg(clock_cfg), .osr_ratio(osr_ratio),
    .conversion_ready_pin(pin), .conversion_ready_oe_n(oe_n), .irq(irq)
  );

  amc_far_model u_far (
    .clk_sys(clk_sys), .srst(srst), .req_done(req_done), .req_take(req_take),
    .req_fail(req_fail), .req_crc(req_crc), .conv_done(conv_done),
    .data_taken(data_taken), .rx_crc_fail(rx_crc_fail), .regmap_crc(regmap_crc)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The whole sequence needs well under two thousand cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string s);
    compares++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k == 16) chk(32'h0, 32'h1, "no ready");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, wd, r, e);
  endtask

  // The error response rides in the top bit, which a mapped read keeps zero.
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk({e, r[30:0]}, {16'h0000, x}, "read");
  endtask

  task automatic ev(input logic [3:0] dn, input logic [3:0] tk, input logic f);
    req_done <= dn;
    req_take <= tk;
    req_fail <= f;
    @(posedge clk_sys);
    req_done <= 4'h0;
    req_take <= 4'h0;
    req_fail <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  function automatic logic [14:0] ratio_exp(input logic [15:0] v);
    return v[5] ? 15'h0040 : 15'(15'h0080 << v[4:2]);
  endfunction

  initial begin
    n = $urandom(43649);
    errors = 0;
    compares = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_done = 4'h0;
    req_take = 4'h0;
    req_fail = 1'b0;
    req_crc = 16'h0000;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(A_MD, 16'h0510); // Mode default.
    wr(A_ST, 32'hFFFF_FFFF);
    rd(A_ST, 16'h0500); // Status default.
    rd(A_CK, 16'h0F0E); // Clock default.
    chk({17'h00000, osr_ratio}, 32'h0000_0400, "ratio rst"); // Default ratio.
    chk({30'h0, oe_n, pin}, 32'h1, "idle"); // Idle driven high.
    apb(1'b0, 8'h20, 32'h0, d, e1);
    chk({31'h0, e1}, 32'h1, "unmapped");
    m = 16'h0510;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      if (i == 3) d[10] = 1'b0;
      m = {d[15:11], m[10] & d[10], d[9:0]};
      wr(A_MD, d);
      rd(A_MD, m); // Mode fields hold.
      rd(A_ST, {4'h0, m[11:8], 8'h00}); // Status mirror.
      chk({16'h0000, mode_cfg}, {16'h0000, m}, "mode port"); // Port follows.
      chk({31'h0, oe_n}, {31'h0, m[1]}, "idle oe"); // Idle release.
    end
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      if (i == 0) d[5:2] = 4'h7;
      if (i == 1) d[5] = 1'b1;
      c = d[15:0] & 16'h0FFF;
      wr(A_CK, d);
      rd(A_CK, c); // Clock fields.
      chk({16'h0000, clock_cfg}, {16'h0000, c}, "clock port"); // Port follows.
      chk({17'h00000, osr_ratio}, {17'h00000, ratio_exp(c)}, "ratio"); // Ratio.
    end
    wr(A_CK, 32'h0F0E);
    wr(A_MD, 32'h0004);
    wr(A_IM, 32'h003F);
    ev(4'h1, 4'h0, 1'b0);
    chk({30'h0, irq, pin}, 32'h2, "or set"); // Any channel drives.
    rd(A_ST, 16'h0001); // Flag set.
    rd(A_IS, 16'h0001);
    ev(4'h0, 4'h1, 1'b0);
    chk({30'h0, irq, pin}, 32'h1, "or clr"); // Flag taken.
    wr(A_CK, 32'h0E0E);
    ev(4'h1, 4'h0, 1'b0);
    rd(A_ST, 16'h0000); // Disabled channel.
    wr(A_CK, 32'h0F0E);
    wr(A_MD, 32'h0000);
    ev(4'h3, 4'h0, 1'b0);
    chk({31'h0, pin}, 32'h1, "lag part"); // Waits for all.
    ev(4'hC, 4'h0, 1'b0);
    chk({31'h0, pin}, 32'h0, "lag all"); // All arrived.
    rd(A_ST, 16'h000F); // Four flags.
    ev(4'h0, 4'hF, 1'b0);
    for (int s = 2; s < 4; s++) begin
      wr(A_MD, {28'h0000000, 2'(s), 2'b00});
      ev(4'h4, 4'h0, 1'b0);
      chk({31'h0, pin}, 32'h0, "lead set"); // First arrival.
      ev(4'h0, 4'h4, 1'b0);
      chk({31'h0, pin}, 32'h1, "lead clr"); // Taken.
    end
    wr(A_MD, 32'h0005);
    req_done <= 4'h2;
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      req_done <= 4'h0;
      if (pin === 1'b0) n++;
    end
    chk(32'(n), 32'h0000_0004, "pulse"); // Fixed low pulse.
    ev(4'h0, 4'h2, 1'b0);
    wr(A_MD, 32'h0000);
    ev(4'h0, 4'h0, 1'b1);
    rd(A_ST, 16'h0000); // Check off.
    wr(A_MD, 32'h1000);
    ev(4'h0, 4'h0, 1'b1);
    rd(A_ST, 16'h1000); // Input error.
    rd(A_ST, 16'h0000); // Read clears.
    wr(A_MD, 32'h2000);
    req_crc <= 16'($urandom) | 16'h0001;
    ev(4'h0, 4'h0, 1'b0);
    rd(A_ST, 16'h2000); // Map changed.
    rd(A_IS, 16'h003F);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "irq clr");
    wr(A_IM, 32'h0000);
    ev(4'h1, 4'h0, 1'b0);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd(A_IS, 16'h0001);
    complete_run();
  end
endmodule // adc_mode_clock_config_regs_tb
`default_nettype wire
